// *** design/amg_area_match.sv ***
// finds the lowest-numbered area whose base..limit window holds an address
// assumes area tables come from flip-flops in the parent
`timescale 1ns/1ps
module amg_area_match (
	input  wire logic [15:0]            addr,
	input  wire logic [15:0]            base [amg_pkg::AREAS],
	input  wire logic [15:0]            limit [amg_pkg::AREAS],
	output logic                        hit,
	output logic [amg_pkg::IDXW-1:0]    idx
);
	logic [amg_pkg::AREAS-1:0] match;

	genvar g;
	generate
		for (g = 0; g < amg_pkg::AREAS; g++) begin : g_area
			// an area with base above limit is empty
			assign match[g] = (addr >= base[g]) && (addr <= limit[g]);
		end
	endgenerate

	// lowest index wins so overlapping areas resolve deterministically
	always_comb begin
		idx = '0;
		for (int i = amg_pkg::AREAS - 1; i >= 0; i--) begin
			if (match[i]) begin
				idx = amg_pkg::IDXW'(i);
			end
		end
	end

	assign hit = |match;
endmodule : amg_area_match

// *** design/amg_area_memory_access_guard.sv ***
// area based memory access guard between core and rom/ram/flash
// assumes core requests are synchronous, one per cycle, with mode and pc
//
// Contract
// - every read, write, delete, execute access from either mode is checked
// - only privileged writes change or lock the area settings
// - rom, ram and flash, data and code, are all guarded
// - decision uses target area, operation and mode, plus code area for user accesses only
// - denied access never reaches memory, nothing stored or returned
// - hardware decides per access, no software in the loop
// - no extra rule forces allow or deny beyond area settings
// - attributes take fixed defaults at reset
// - defaults or software-loaded values govern all checks
`timescale 1ns/1ps
module amg_area_memory_access_guard (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        req_valid,
	input  wire logic [15:0] req_addr,
	input  wire logic [1:0]  req_op,
	input  wire logic        req_priv,
	input  wire logic [15:0] req_pc,
	input  wire logic        cfg_we,
	input  wire logic        cfg_priv,
	input  wire logic [1:0]  cfg_area,
	input  wire logic [1:0]  cfg_sel,
	input  wire logic [15:0] cfg_wdata,
	output logic             mem_req_ff,
	output logic [15:0]      mem_addr_ff,
	output logic [1:0]       mem_op_ff,
	output logic [2:0]       mem_sel_ff,
	output logic             viol_ff,
	output logic [15:0]      viol_addr_ff,
	output logic [1:0]       viol_op_ff,
	output logic             viol_priv_ff,
	output logic [15:0]      cfg_rdata_ff,
	output logic             cfg_reject_ff,
	output logic             cfg_locked_ff
);
	logic [15:0]               base_ff [amg_pkg::AREAS];
	logic [15:0]               limit_ff [amg_pkg::AREAS];
	logic [15:0]               attr_ff [amg_pkg::AREAS];
	logic                      tgt_hit;
	logic [amg_pkg::IDXW-1:0]  tgt_idx;
	logic                      src_hit;
	logic [amg_pkg::IDXW-1:0]  src_idx;
	logic [15:0]               tgt_attr;
	logic                      perm_bit;
	logic                      src_ok;
	logic                      allowed;
	logic                      cfg_take;
	logic [2:0]                nxt_sel;

	// a lock is the final acceptance: after it not even privileged code may edit
	assign cfg_take = cfg_we && cfg_priv && !cfg_locked_ff;

	// area table, defaults are fixed constants until software reloads them
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < amg_pkg::AREAS; i++) begin
				base_ff[i]  <= (i == 0) ? amg_pkg::DEF_BASE0 : amg_pkg::DEF_BASE;
				limit_ff[i] <= (i == 0) ? amg_pkg::DEF_LIMIT0 : amg_pkg::DEF_LIMIT;
				attr_ff[i]  <= (i == 0) ? amg_pkg::DEF_ATTR0 : amg_pkg::DEF_ATTR;
			end
		end else if (cfg_take) begin
			unique case (cfg_sel)
				amg_pkg::SEL_BASE:  base_ff[cfg_area]  <= cfg_wdata;
				amg_pkg::SEL_LIMIT: limit_ff[cfg_area] <= cfg_wdata;
				amg_pkg::SEL_ATTR:  attr_ff[cfg_area]  <= cfg_wdata;
				amg_pkg::SEL_LOCK:  ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_locked_ff <= 1'b0;
		end else if (cfg_take && cfg_sel == amg_pkg::SEL_LOCK && cfg_wdata[0]) begin
			cfg_locked_ff <= 1'b1;
		end
	end

	// user writes and writes after lock are dropped and flagged for one cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_reject_ff <= 1'b0;
		end else begin
			cfg_reject_ff <= cfg_we && !cfg_take;
		end
	end

	// readback of the selected word so software can confirm its settings
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_rdata_ff <= 16'h0000;
		end else begin
			unique case (cfg_sel)
				amg_pkg::SEL_BASE:  cfg_rdata_ff <= base_ff[cfg_area];
				amg_pkg::SEL_LIMIT: cfg_rdata_ff <= limit_ff[cfg_area];
				amg_pkg::SEL_ATTR:  cfg_rdata_ff <= attr_ff[cfg_area];
				amg_pkg::SEL_LOCK:  cfg_rdata_ff <= {15'h0000, cfg_locked_ff};
			endcase
		end
	end

	amg_area_match u_tgt (
		.addr  (req_addr),
		.base  (base_ff),
		.limit (limit_ff),
		.hit   (tgt_hit),
		.idx   (tgt_idx)
	);

	amg_area_match u_src (
		.addr  (req_pc),
		.base  (base_ff),
		.limit (limit_ff),
		.hit   (src_hit),
		.idx   (src_idx)
	);

	// decision is pure table lookup; no override input exists
	always_comb begin
		tgt_attr = attr_ff[tgt_idx];
		if (req_priv) begin
			perm_bit = tgt_attr[amg_pkg::ATTR_PRIV_LSB + int'(req_op)];
		end else begin
			perm_bit = tgt_attr[amg_pkg::ATTR_USER_LSB + int'(req_op)];
		end
		// user code may touch an area only from a code area listed in its mask
		src_ok  = req_priv || (src_hit && tgt_attr[amg_pkg::ATTR_SRC_LSB + int'(src_idx)]);
		allowed = tgt_hit && perm_bit && src_ok;
	end

	always_comb begin
		if (req_addr <= amg_pkg::ROM_LAST) begin
			nxt_sel = amg_pkg::MSEL_ROM;
		end else if (req_addr <= amg_pkg::RAM_LAST) begin
			nxt_sel = amg_pkg::MSEL_RAM;
		end else begin
			nxt_sel = amg_pkg::MSEL_FLASH;
		end
	end

	// memory strobe only for a permitted access; address zeroed otherwise
	// so a refused request leaves no trace on the memory side
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mem_req_ff  <= 1'b0;
			mem_addr_ff <= 16'h0000;
			mem_op_ff   <= 2'h0;
			mem_sel_ff  <= 3'h0;
		end else begin
			mem_req_ff  <= req_valid && allowed;
			mem_addr_ff <= (req_valid && allowed) ? req_addr : 16'h0000;
			mem_op_ff   <= (req_valid && allowed) ? req_op : 2'h0;
			mem_sel_ff  <= (req_valid && allowed) ? nxt_sel : 3'h0;
		end
	end

	// violation report, one-cycle pulse with details held until the next one
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			viol_ff      <= 1'b0;
			viol_addr_ff <= 16'h0000;
			viol_op_ff   <= 2'h0;
			viol_priv_ff <= 1'b0;
		end else begin
			viol_ff <= req_valid && !allowed;
			if (req_valid && !allowed) begin
				viol_addr_ff <= req_addr;
				viol_op_ff   <= req_op;
				viol_priv_ff <= req_priv;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_every_access: assert property (req_valid |=> (mem_req_ff ^ viol_ff))
		else $error("access neither granted nor refused");
	a_user_cfg_block: assert property (cfg_we && !cfg_priv |=>
		cfg_reject_ff && attr_ff[$past(cfg_area)] == $past(attr_ff[cfg_area]))
		else $error("user write altered attributes");
	a_lock_holds: assert property (cfg_locked_ff && cfg_we |=>
		cfg_reject_ff && cfg_locked_ff && base_ff[$past(cfg_area)] == $past(base_ff[cfg_area]))
		else $error("write after lock was taken");
	a_mem_sel_map: assert property (mem_req_ff |->
		mem_sel_ff == ((mem_addr_ff <= amg_pkg::ROM_LAST) ? amg_pkg::MSEL_ROM :
		(mem_addr_ff <= amg_pkg::RAM_LAST) ? amg_pkg::MSEL_RAM : amg_pkg::MSEL_FLASH))
		else $error("wrong memory selected");
	a_user_no_perm: assert property (req_valid && !req_priv && tgt_hit &&
		!attr_ff[tgt_idx][amg_pkg::ATTR_USER_LSB + int'(req_op)] |=> viol_ff && !mem_req_ff)
		else $error("user access without permission granted");
	a_deny_silent: assert property (viol_ff |-> !mem_req_ff && mem_addr_ff == 16'h0000)
		else $error("denied access reached memory");
	a_grant_next: assert property (req_valid && allowed |=>
		mem_req_ff && mem_addr_ff == $past(req_addr) && mem_op_ff == $past(req_op))
		else $error("permitted access not forwarded");
	a_idle_quiet: assert property (!req_valid |=> !mem_req_ff && !viol_ff)
		else $error("output without request");
	// checked at the edge after release, since before the first edge in reset the table is unknown
	a_reset_default: assert property (disable iff (1'b0)
		$fell(reset) |-> attr_ff[0] == amg_pkg::DEF_ATTR0 && limit_ff[0] == amg_pkg::DEF_LIMIT0)
		else $error("attribute default missing in reset");
	a_priv_cfg_take: assert property (cfg_take && cfg_sel == amg_pkg::SEL_ATTR |=>
		attr_ff[$past(cfg_area)] == $past(cfg_wdata))
		else $error("privileged write not stored");
	a_viol_detail: assert property (req_valid && !allowed |=>
		viol_addr_ff == $past(req_addr) && viol_op_ff == $past(req_op))
		else $error("violation details wrong");
	a_src_mask: assert property (req_valid && !req_priv && src_hit &&
		!attr_ff[tgt_idx][amg_pkg::ATTR_SRC_LSB + int'(src_idx)] |=> viol_ff && !mem_req_ff)
		else $error("user access from unlisted code area granted");

	c_user_grant: cover property (req_valid && !req_priv && allowed ##1 mem_req_ff);
	c_user_viol: cover property (req_valid && !req_priv && !allowed ##1 viol_ff);
	c_cfg_reject: cover property (cfg_we && !cfg_priv ##1 cfg_reject_ff);
	c_lock_then_write: cover property (cfg_locked_ff && cfg_we && cfg_priv ##1 cfg_reject_ff);
	c_priv_flash: cover property (req_valid && req_priv && allowed &&
		req_addr > amg_pkg::RAM_LAST ##1 mem_req_ff);
endmodule : amg_area_memory_access_guard

// *** design/amg_pkg.sv ***
// constants, types and reset defaults for the area memory access guard
// assumes a 16-bit address space shared by rom, ram and flash
package amg_pkg;
	localparam int          AREAS        = 4;
	localparam int          IDXW         = 2;
	localparam int          AW           = 16;
	localparam int          DW           = 16;

	typedef enum logic [1:0] {
		AMG_OP_READ   = 2'h0,
		AMG_OP_WRITE  = 2'h1,
		AMG_OP_DELETE = 2'h2,
		AMG_OP_EXEC   = 2'h3
	} amg_op_t;

	// configuration word select
	localparam logic [1:0]  SEL_BASE     = 2'h0;
	localparam logic [1:0]  SEL_LIMIT    = 2'h1;
	localparam logic [1:0]  SEL_ATTR     = 2'h2;
	localparam logic [1:0]  SEL_LOCK     = 2'h3;

	// attribute word field positions
	localparam int          ATTR_PRIV_LSB = 0;
	localparam int          ATTR_USER_LSB = 4;
	localparam int          ATTR_SRC_LSB  = 8;

	// reset defaults: area 0 spans all memory, privileged only
	localparam logic [15:0] DEF_BASE0    = 16'h0000;
	localparam logic [15:0] DEF_LIMIT0   = 16'hffff;
	localparam logic [15:0] DEF_ATTR0    = 16'h000f;
	localparam logic [15:0] DEF_BASE     = 16'hffff;
	localparam logic [15:0] DEF_LIMIT    = 16'h0000;
	localparam logic [15:0] DEF_ATTR     = 16'h0000;

	// memory map and one-hot memory selects
	localparam logic [15:0] ROM_LAST     = 16'h7fff;
	localparam logic [15:0] RAM_LAST     = 16'hbfff;
	localparam logic [2:0]  MSEL_ROM     = 3'h1;
	localparam logic [2:0]  MSEL_RAM     = 3'h2;
	localparam logic [2:0]  MSEL_FLASH   = 3'h4;
endpackage : amg_pkg

// *** tb/amg_core_model.sv ***
// core model: issues one checked access per call on the request side
// assumes the guard samples requests on the rising edge of clk
`timescale 1ns/1ps
module amg_core_model (
	input  wire logic        clk,
	output logic             req_valid,
	output logic [15:0]      req_addr,
	output logic [1:0]       req_op,
	output logic             req_priv,
	output logic [15:0]      req_pc
);
	initial begin
		req_valid = 1'b0;
		req_addr  = 16'h0000;
		req_op    = 2'h0;
		req_priv  = 1'b0;
		req_pc    = 16'h0000;
	end

	// idle lines except req_priv show the inverse so a stale value never looks valid
	task automatic issue(input logic [15:0] a, input logic [1:0] o, input logic p,
		input logic [15:0] pc);
		@(negedge clk);
		req_valid = 1'b1;
		req_addr  = a;
		req_op    = o;
		req_priv  = p;
		req_pc    = pc;
		@(negedge clk);
		req_valid = 1'b0;
		req_addr  = ~a;
		req_op    = ~o;
		req_pc    = ~pc;
	endtask : issue
endmodule : amg_core_model

// *** tb/area_memory_access_guard_tb.sv ***
// testbench for the area memory access guard
// assumes the core model drives requests; the bench drives the config port
`timescale 1ns/1ps
module area_memory_access_guard_tb;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        req_valid, req_priv, cfg_we = 1'b0, cfg_priv = 1'b0;
	logic [15:0] req_addr, req_pc, cfg_wdata = 16'h0000;
	logic [1:0]  req_op, cfg_area = 2'h0, cfg_sel = 2'h0, mem_op_ff, viol_op_ff;
	logic        mem_req_ff, viol_ff, viol_priv_ff, cfg_reject_ff, cfg_locked_ff;
	logic [15:0] mem_addr_ff, viol_addr_ff, cfg_rdata_ff;
	logic [2:0]  mem_sel_ff, esel;
	int          mismatches = 0;
	int          checked = 0;

	initial begin
		forever #10 clk = ~clk;
	end

	amg_core_model core (.clk(clk), .req_valid(req_valid), .req_addr(req_addr),
		.req_op(req_op), .req_priv(req_priv), .req_pc(req_pc));

	amg_area_memory_access_guard dut (.clk(clk), .reset(reset), .req_valid(req_valid),
		.req_addr(req_addr), .req_op(req_op), .req_priv(req_priv), .req_pc(req_pc),
		.cfg_we(cfg_we), .cfg_priv(cfg_priv), .cfg_area(cfg_area), .cfg_sel(cfg_sel),
		.cfg_wdata(cfg_wdata), .mem_req_ff(mem_req_ff), .mem_addr_ff(mem_addr_ff),
		.mem_op_ff(mem_op_ff), .mem_sel_ff(mem_sel_ff), .viol_ff(viol_ff),
		.viol_addr_ff(viol_addr_ff), .viol_op_ff(viol_op_ff), .viol_priv_ff(viol_priv_ff),
		.cfg_rdata_ff(cfg_rdata_ff), .cfg_reject_ff(cfg_reject_ff),
		.cfg_locked_ff(cfg_locked_ff));

	task automatic give_verdict();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	// one access through the core model, then grant judged on all memory outputs, refusal on strobe, select and violation details
	task automatic access(input logic [15:0] a, input logic [1:0] o, input logic p,
		input logic [15:0] pc, input logic g);
		core.issue(a, o, p, pc);
		esel = (a <= amg_pkg::ROM_LAST) ? amg_pkg::MSEL_ROM :
			(a <= amg_pkg::RAM_LAST) ? amg_pkg::MSEL_RAM : amg_pkg::MSEL_FLASH;
		checked++;
		if (g ? (mem_req_ff !== 1'b1 || viol_ff !== 1'b0 || mem_addr_ff !== a ||
			mem_op_ff !== o || mem_sel_ff !== esel) :
			(mem_req_ff !== 1'b0 || viol_ff !== 1'b1 || mem_sel_ff !== 3'h0 ||
			viol_addr_ff !== a || viol_op_ff !== o || viol_priv_ff !== p)) begin
			mismatches++;
			$display("BAD %0t access %h op %0d grant %0d wrong", $time, a, o, g);
		end
	endtask : access

	task automatic cfg_write(input logic p, input logic [1:0] ar, input logic [1:0] s,
		input logic [15:0] d, input logic rej);
		@(negedge clk);
		{cfg_we, cfg_priv, cfg_area, cfg_sel, cfg_wdata} = {1'b1, p, ar, s, d};
		@(negedge clk);
		cfg_we = 1'b0;
		chk_word({15'h0000, cfg_reject_ff}, {15'h0000, rej});
	endtask : cfg_write

	task automatic cfg_read(input logic [1:0] ar, input logic [1:0] s,
		input logic [15:0] exp);
		@(negedge clk);
		{cfg_area, cfg_sel} = {ar, s};
		@(negedge clk);
		chk_word(cfg_rdata_ff, exp);
	endtask : cfg_read

	task automatic t_defaults();
		cfg_read(2'h0, amg_pkg::SEL_LIMIT, amg_pkg::DEF_LIMIT0);
		cfg_read(2'h0, amg_pkg::SEL_ATTR, amg_pkg::DEF_ATTR0);
		cfg_read(2'h2, amg_pkg::SEL_BASE, amg_pkg::DEF_BASE);
		for (int k = 0; k < 4; k++) begin
			access(16'h1234 + 16'(k) * 16'h4000, 2'(k), 1'b1, 16'h0100, 1'b1);
		end
		access(16'h0200, amg_pkg::AMG_OP_READ, 1'b0, 16'h0100, 1'b0);
	endtask : t_defaults

	task automatic t_user_write_dropped();
		cfg_write(1'b0, 2'h0, amg_pkg::SEL_ATTR, 16'h00ff, 1'b1);
		cfg_read(2'h0, amg_pkg::SEL_ATTR, amg_pkg::DEF_ATTR0);
		access(16'h0200, amg_pkg::AMG_OP_READ, 1'b0, 16'h0100, 1'b0);
	endtask : t_user_write_dropped

	// area 0 shrunk to rom, area 1 is ram: user read only, from area 0 code
	task automatic t_areas();
		cfg_write(1'b1, 2'h0, amg_pkg::SEL_LIMIT, 16'h7fff, 1'b0);
		cfg_write(1'b1, 2'h1, amg_pkg::SEL_BASE, 16'h8000, 1'b0);
		cfg_write(1'b1, 2'h1, amg_pkg::SEL_LIMIT, 16'hbfff, 1'b0);
		cfg_write(1'b1, 2'h1, amg_pkg::SEL_ATTR, 16'h011f, 1'b0);
		cfg_read(2'h1, amg_pkg::SEL_ATTR, 16'h011f);
		access(16'h8100, amg_pkg::AMG_OP_READ, 1'b0, 16'h0100, 1'b1);
		access(16'h8100, amg_pkg::AMG_OP_WRITE, 1'b0, 16'h0100, 1'b0);
		access(16'h8100, amg_pkg::AMG_OP_READ, 1'b0, 16'h8000, 1'b0);
		access(16'hbfff, amg_pkg::AMG_OP_DELETE, 1'b1, 16'h8000, 1'b1);
		access(16'hc000, amg_pkg::AMG_OP_EXEC, 1'b1, 16'h0100, 1'b0);
		access(16'h7fff, amg_pkg::AMG_OP_WRITE, 1'b0, 16'h0100, 1'b0);
	endtask : t_areas

	task automatic t_lock();
		cfg_write(1'b1, 2'h0, amg_pkg::SEL_LOCK, 16'h0001, 1'b0);
		chk_word({15'h0000, cfg_locked_ff}, 16'h0001);
		cfg_read(2'h0, amg_pkg::SEL_LOCK, 16'h0001);
		cfg_write(1'b1, 2'h1, amg_pkg::SEL_ATTR, 16'h001f, 1'b1);
		cfg_read(2'h1, amg_pkg::SEL_ATTR, 16'h011f);
		access(16'h8100, amg_pkg::AMG_OP_READ, 1'b0, 16'h0100, 1'b1);
	endtask : t_lock

	initial begin
		repeat (2) @(negedge clk);
		reset = 1'b0;
		t_defaults();
		t_user_write_dropped();
		t_areas();
		t_lock();
		give_verdict();
	end

	// the sequence needs well under 200 cycles
	initial begin
		#20000;
		mismatches++;
		give_verdict();
	end
endmodule : area_memory_access_guard_tb
